//--- verilog/rtcis_slave.v
`timescale 1ns/100ps
`include "rtcis_defs.vh"

module rtcis_slave
(
  input  wire       mclk_i,
  input  wire       rstn_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  input  wire       on_backup_i,
  input  wire       cal_nv_valid_i,
  input  wire [7:0] cal_nv_data_i,
  output reg  [7:0] cal_addr_o,
  output reg        cal_we_o,
  output reg  [7:0] cal_data_o,
  output reg        recall_done_o,
  output wire       wr_valid_o,
  input  wire       wr_ready_i,
  output wire [8:0] wr_data_o,
  output reg        wr_space_o,
  output reg  [7:0] wr_addr_o,
  output reg        rd_req_o,
  output reg        rd_space_o,
  output reg  [7:0] rd_addr_o,
  input  wire [7:0] rd_data_i
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_DEVID = 3'd1;
  localparam ST_WADDR = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;
  localparam ST_RACK  = 3'd5;
  localparam ST_WAIT  = 3'd6;

  wire       scl_s;
  wire       sda_s;
  reg        scl_q;
  reg        sda_q;
  reg  [2:0] st_q;
  reg  [3:0] bit_q;
  reg  [7:0] sh_q;
  reg  [7:0] ptr_q;
  reg        space_q;
  reg        ack_q;
  reg        drv_q;
  wire       on_backup_s;
  reg        fifo_push_q;
  reg  [8:0] fifo_word_q;
  reg  [7:0] tx_q;
  wire       fifo_ready;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_c;
  wire       stop_c;
  wire       active;
  wire [7:0] rx_byte;
  wire [7:0] ptr_next;

  rtcis_sync u_scl_sync
  (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .async_i(scl_i),
    .sync_o (scl_s)
  );
  rtcis_sync u_sda_sync
  (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .async_i(sda_i),
    .sync_o (sda_s)
  );
  rtcis_sync u_bkp_sync
  (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .async_i(on_backup_i),
    .sync_o (on_backup_s)
  );

  // edges while clock high are framing
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  // no response before recall completes or on backup
  assign active   = recall_done_o & ~on_backup_s;
  assign rx_byte  = {sh_q[6:0], sda_s};

  // per-space wrap of the read pointer
  assign ptr_next = (space_q ? (ptr_q == `RTCIS_USER_MEM_LAST)
                             : (ptr_q == `RTCIS_CLOCK_SPACE_LAST))
                    ? `RTCIS_PTR_RESET : ptr_q + 8'h01;

  assign sda_o    = 1'b0;
  assign sda_oe_o = drv_q & active;

  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      cal_addr_o    <= 8'h00;
      cal_we_o      <= 1'b0;
      cal_data_o    <= 8'h00;
      recall_done_o <= 1'b0;
    end
    else
    begin
      cal_we_o <= 1'b0;
      if (!recall_done_o && cal_nv_valid_i)
      begin
        cal_we_o   <= 1'b1;
        cal_data_o <= cal_nv_data_i;
        cal_addr_o <= cal_addr_o + 8'h01;
        if (cal_addr_o == `RTCIS_RECALL_CYCLES - 8'h01)
          recall_done_o <= 1'b1;
      end
    end
  end

  // write words go through the fifo; data byte tagged with space in bit 8
  rtcis_fifo #(
    .WIDTH(`RTCIS_FIFO_WIDTH),
    .DEPTH(`RTCIS_FIFO_DEPTH),
    .AW   (3)
  ) u_fifo
  (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .in_valid_i (fifo_push_q),
    .in_ready_o (fifo_ready),
    .in_data_i  (fifo_word_q),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o (wr_data_o)
  );

  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      st_q        <= ST_IDLE;
      bit_q       <= 4'd0;
      sh_q        <= 8'h00;
      ptr_q       <= `RTCIS_PTR_RESET;
      space_q     <= 1'b0;
      ack_q       <= 1'b0;
      drv_q       <= 1'b0;
      fifo_push_q <= 1'b0;
      fifo_word_q <= 9'h000;
      tx_q        <= 8'h00;
      wr_space_o  <= 1'b0;
      wr_addr_o   <= 8'h00;
      rd_req_o    <= 1'b0;
      rd_space_o  <= 1'b0;
      rd_addr_o   <= 8'h00;
    end
    else
    begin
      scl_q       <= scl_s;
      sda_q       <= sda_s;
      fifo_push_q <= 1'b0;
      rd_req_o    <= 1'b0;
      if (!active)
      begin
        st_q  <= ST_IDLE;
        drv_q <= 1'b0;
      end
      else if (start_c)
      begin
        // start (or repeated start) opens an address byte
        st_q  <= ST_DEVID;
        bit_q <= 4'd0;
        drv_q <= 1'b0;
        ack_q <= 1'b0;
      end
      else if (stop_c)
      begin
        st_q  <= ST_IDLE;
        drv_q <= 1'b0;
      end
      else if (st_q == ST_RDATA)
      begin
        // shift out on falling edges, msb first
        if (scl_fall)
        begin
          if (bit_q == 4'd8)
          begin
            drv_q <= 1'b0;
            st_q  <= ST_RACK;
          end
          else
          begin
            drv_q <= ~tx_q[7];
            tx_q  <= {tx_q[6:0], 1'b1};
            bit_q <= bit_q + 4'd1;
          end
        end
      end
      else if (st_q == ST_RACK)
      begin
        if (scl_rise)
        begin
          // advance; fetch more only on ack
          ptr_q      <= ptr_next;
          rd_req_o   <= ~sda_s;
          rd_space_o <= space_q;
          rd_addr_o  <= ptr_next;
          st_q       <= ST_WAIT;
          ack_q      <= ~sda_s;
        end
      end
      else if (st_q == ST_WAIT)
      begin
        // after an ack, load the fetched byte and drive its first bit
        if (ack_q && scl_fall)
        begin
          tx_q  <= {rd_data_i[6:0], 1'b1};
          drv_q <= ~rd_data_i[7];
          bit_q <= 4'd1;
          st_q  <= ST_RDATA;
          ack_q <= 1'b0;
        end
      end
      else if (st_q != ST_IDLE)
      begin
        // receive phase: sample on rise, ack window on ninth clock
        if (scl_rise && bit_q < 4'd8)
        begin
          sh_q  <= rx_byte;
          bit_q <= bit_q + 4'd1;
          if (bit_q == 4'd7)
          begin
            if (st_q == ST_DEVID)
            begin
              ack_q   <= (rx_byte[7:1] == `RTCIS_ID_CLOCK_SPACE) |
                         (rx_byte[7:1] == `RTCIS_ID_USER_MEM);
              space_q <= (rx_byte[7:1] == `RTCIS_ID_USER_MEM);
              if (rx_byte[0] == `RTCIS_DIR_READ)
              begin
                rd_req_o   <= 1'b1;
                rd_space_o <= (rx_byte[7:1] == `RTCIS_ID_USER_MEM);
                rd_addr_o  <= ptr_q;
              end
            end
            else if (st_q == ST_WDATA)
              ack_q <= fifo_ready;
            else
              ack_q <= 1'b1;
          end
        end
        else if (scl_fall && bit_q == 4'd8 && !drv_q)
        begin
          // drive ack for the ninth clock
          if (ack_q)
            drv_q <= 1'b1;
          else
            st_q <= ST_IDLE;
        end
        else if (scl_fall && bit_q == 4'd8 && drv_q)
        begin
          drv_q <= 1'b0;
          bit_q <= 4'd0;
          if (st_q == ST_DEVID)
          begin
            if (sh_q[0] == `RTCIS_DIR_READ)
            begin
              tx_q  <= {rd_data_i[6:0], 1'b1};
              drv_q <= ~rd_data_i[7];
              bit_q <= 4'd1;
              st_q  <= ST_RDATA;
            end
            else
              st_q <= ST_WADDR;
          end
          else if (st_q == ST_WADDR)
          begin
            ptr_q      <= sh_q;
            rd_req_o   <= 1'b1;
            rd_space_o <= space_q;
            rd_addr_o  <= sh_q;
            st_q       <= ST_WDATA;
          end
          else
          begin
            // single data byte written, then standby
            fifo_push_q <= 1'b1;
            fifo_word_q <= {space_q, sh_q};
            wr_space_o  <= space_q;
            wr_addr_o   <= ptr_q;
            st_q        <= ST_IDLE;
          end
        end
      end
    end
  end
endmodule // rtcis_slave

//--- verilog/rtcis_defs.vh
`ifndef RTCIS_DEFS_VH
`define RTCIS_DEFS_VH
// slave identifiers (upper seven bits of the address byte)
`define RTCIS_ID_CLOCK_SPACE 7'h6f
`define RTCIS_ID_USER_MEM    7'h57
// direction bit value that requests a read
`define RTCIS_DIR_READ       1'b1
// pointer reset value and wrap points
`define RTCIS_PTR_RESET      8'h00
`define RTCIS_CLOCK_SPACE_LAST 8'h2f
`define RTCIS_USER_MEM_LAST  8'h7f
// fifo geometry
`define RTCIS_FIFO_WIDTH     9
`define RTCIS_FIFO_DEPTH     8
// calibration recall length in recalled bytes (cycles with cal_nv_valid_i high)
`define RTCIS_RECALL_CYCLES  8'h10
`endif

//--- verilog/rtcis_sync.v
`timescale 1ns/100ps
// two-flop synchroniser for one asynchronous level
module rtcis_sync
(
  input  wire mclk_i,
  input  wire rstn_i,
  input  wire async_i,
  output wire sync_o
);
  reg meta_q;
  reg sync_q;

  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // rtcis_sync

//--- verilog/rtcis_fifo.v
`timescale 1ns/100ps
// small flop fifo with valid/ready on both sides
module rtcis_fifo
#(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  input  wire             mclk_i,
  input  wire             rstn_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  always @(posedge mclk_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end

  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // rtcis_fifo

//--- testbench/rtcis_master.sv
`timescale 1ns/100ps
module rtcis_master
(
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic bit_x(input logic b, output logic r);
    #12 sda_oe_o = !b;
    #12 scl_o = 1'b1;
    #20 r = sda_i;
    #4 scl_o = 1'b0;
  endtask
  task automatic start;
    #12 sda_oe_o = 1'b0;
    #12 scl_o = 1'b1;
    #24 sda_oe_o = 1'b1;
    #24 scl_o = 1'b0;
  endtask
  task automatic stop;
    #12 sda_oe_o = 1'b1;
    #12 scl_o = 1'b1;
    #24 sda_oe_o = 1'b0;
    #24;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(a, k);
  endtask
endmodule // rtcis_master

//--- testbench/rtcis_slave_checker.sv
`timescale 1ns/100ps
module rtcis_slave_checker
(
  input wire       mclk_i,
  input wire       rstn_i,
  input wire       scl_i,
  input wire       sda_o,
  input wire       sda_oe_o,
  input wire       on_backup_i,
  input wire       cal_we_o,
  input wire       recall_done_o,
  input wire       wr_valid_o,
  input wire       wr_ready_i,
  input wire [8:0] wr_data_o,
  input wire       rd_req_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_stall;
    wr_valid_o && !wr_ready_i;
  endsequence
  sequence s_held;
    wr_valid_o && $stable(wr_data_o);
  endsequence
  property p_quiet;
    !recall_done_o |-> !sda_oe_o && !rd_req_o && !wr_valid_o;
  endproperty
  property p_backup;
    on_backup_i [*8] |-> !sda_oe_o;
  endproperty
  property p_oe_chg;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  property p_drive;
    sda_oe_o |-> !sda_o;
  endproperty
  property p_rdreq;
    rd_req_o |=> !rd_req_o;
  endproperty
  property p_recall_end;
    recall_done_o && $past(recall_done_o) |-> !cal_we_o;
  endproperty
  property p_recall_stay;
    recall_done_o |=> recall_done_o;
  endproperty
  property p_wr_hold;
    s_stall |=> s_held;
  endproperty
  a_quiet: assert property (p_quiet) else $error("active before recall");
  a_backup: assert property (p_backup) else $error("drive on backup");
  a_oe_chg: assert property (p_oe_chg) else $error("data moved in clock high");
  a_drive: assert property (p_drive) else $error("drive not low");
  a_rdreq: assert property (p_rdreq) else $error("read request too long");
  a_recall_end: assert property (p_recall_end) else $error("write after recall");
  a_recall_stay: assert property (p_recall_stay) else $error("recall flag fell");
  a_wr_hold: assert property (p_wr_hold) else $error("word lost in stall");
endmodule // rtcis_slave_checker
bind rtcis_slave rtcis_slave_checker chk_u (.mclk_i, .rstn_i, .scl_i, .sda_o, .sda_oe_o,
  .on_backup_i, .cal_we_o, .recall_done_o, .wr_valid_o, .wr_ready_i, .wr_data_o, .rd_req_o);

//--- testbench/test_rtcis_slave.sv
`timescale 1ns/100ps
`include "rtcis_defs.vh"
module test_rtcis_slave;
  logic       mclk_i, rstn_i, on_backup_i, cal_nv_valid_i, wr_ready_i, m_oe, ack;
  logic [7:0] cal_nv_data_i, q;
  wire        scl, sda_o, sda_oe_o, cal_we_o, recall_done_o, wr_valid_o, wr_space_o;
  wire        rd_req_o, rd_space_o;
  wire  [7:0] cal_addr_o, cal_data_o, wr_addr_o, rd_addr_o, rd_data_i;
  wire  [8:0] wr_data_o;
  int         err_total, comparisons, cyc, we_cnt;
  // open drain with pull-up
  wire sda = !m_oe & (sda_oe_o ? sda_o : 1'b1);
  assign rd_data_i = {rd_space_o, rd_addr_o[6:0]} ^ 8'ha5;
  rtcis_slave dut_u (.mclk_i, .rstn_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o,
    .on_backup_i, .cal_nv_valid_i, .cal_nv_data_i, .cal_addr_o, .cal_we_o, .cal_data_o,
    .recall_done_o, .wr_valid_o, .wr_ready_i, .wr_data_o, .wr_space_o, .wr_addr_o,
    .rd_req_o, .rd_space_o, .rd_addr_o, .rd_data_i);
  rtcis_master m (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = !mclk_i;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cal_we_o === 1'b1)
      we_cnt++;
    if (cyc == 30000)
    begin
      err_total++;
      test_done;
    end
  end
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic e);
    m.xfer(d, 1'b1, q, ack);
    chk({8'h00, ack}, {8'h00, e});
  endtask
  task automatic t_recall;
    chk({8'h00, sda_oe_o}, 9'h000);
    for (int i = 0; i < 40 && recall_done_o !== 1'b1; i++)
      @(posedge mclk_i);
    #1 chk(we_cnt[8:0], 9'h010);
    chk({1'b0, cal_data_o}, 9'h03c);
    chk({1'b0, cal_addr_o}, {1'b0, `RTCIS_RECALL_CYCLES});
    $display("recall test done");
  endtask
  task automatic t_read(input logic [6:0] id, input logic [7:0] a, input int n);
    logic [7:0] p;
    logic [7:0] last;
    p = a;
    last = (id == `RTCIS_ID_USER_MEM) ? `RTCIS_USER_MEM_LAST : `RTCIS_CLOCK_SPACE_LAST;
    m.start;
    wb({id, 1'b0}, 1'b0);
    wb(a, 1'b0);
    // same id on both phases
    m.start;
    wb({id, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      m.xfer(8'hff, i == n - 1, q, ack);
      chk({1'b0, q}, {1'b0, {id == `RTCIS_ID_USER_MEM, p[6:0]} ^ 8'ha5});
      p = (p == last) ? 8'h00 : p + 8'h01;
    end
    m.stop;
    chk({8'h00, sda_oe_o}, 9'h000);
    // a later read without word address continues at the pointer
    m.start;
    wb({id, 1'b1}, 1'b0);
    m.xfer(8'hff, 1'b1, q, ack);
    chk({1'b0, q}, {1'b0, {id == `RTCIS_ID_USER_MEM, p[6:0]} ^ 8'ha5});
    m.stop;
    $display("read test done");
  endtask
  task automatic t_cur_read;
    m.start;
    wb({`RTCIS_ID_CLOCK_SPACE, 1'b1}, 1'b0);
    m.xfer(8'hff, 1'b1, q, ack);
    chk({1'b0, q}, 9'h0a5);
    m.stop;
    $display("current address read test done");
  endtask
  task automatic t_bad_id;
    m.start;
    wb(8'haa, 1'b1);
    m.stop;
    $display("bad id test done");
  endtask
  task automatic t_backup;
    @(posedge mclk_i) on_backup_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    #1 m.start;
    wb({`RTCIS_ID_CLOCK_SPACE, 1'b0}, 1'b1);
    m.stop;
    $display("backup test done");
  endtask
  task automatic t_write;
    for (int k = 0; k < 9; k++)
    begin
      m.start;
      wb({k[0] ? `RTCIS_ID_USER_MEM : `RTCIS_ID_CLOCK_SPACE, 1'b0}, 1'b0);
      wb(8'h10 + k[7:0], 1'b0);
      wb(8'h30 + k[7:0], k == 8);
      m.stop;
      if (k < 8)
        chk({wr_space_o, wr_addr_o}, {k[0], 8'h10 + k[7:0]});
    end
    for (int k = 0; k < 8; k++)
    begin
      #1;
      for (int i = 0; i < 20 && wr_valid_o !== 1'b1; i++)
        @(posedge mclk_i);
      chk(wr_data_o, {k[0], 8'h30 + k[7:0]});
      @(posedge mclk_i) wr_ready_i <= 1'b1;
      @(posedge mclk_i) wr_ready_i <= 1'b0;
    end
    #1 chk({8'h00, wr_valid_o}, 9'h000);
    $display("write test done");
  endtask
  initial
  begin
    rstn_i = 1'b0;
    on_backup_i = 1'b0;
    cal_nv_valid_i = 1'b0;
    cal_nv_data_i = 8'h3c;
    wr_ready_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    cal_nv_valid_i <= 1'b1;
    t_recall;
    t_cur_read;
    t_bad_id;
    t_write;
    t_read(`RTCIS_ID_CLOCK_SPACE, 8'h2f, 3);
    t_read(`RTCIS_ID_USER_MEM, 8'h7f, 2);
    t_backup;
    test_done;
  end
endmodule // test_rtcis_slave
